/* File: logic/pstb_aux_monitor.sv */
`include "pstb_cfg.svh"
`default_nettype none

module pstb_aux_monitor
(
  input wire logic sampleValid,
  input wire logic [15:0] sample,
  input wire logic [15:0] lowLimit,
  input wire logic [15:0] highLimit,
  output logic lowWarn,
  output logic highWarn,
  output logic lowFault,
  output logic highFault
);

  logic [23:0] sampleScaled;
  logic [23:0] lowScaled;
  logic [23:0] highScaled;

  // compare in percent units so no divider is needed
  assign sampleScaled = 24'(sample) * 24'h64;
  assign lowScaled = 24'(lowLimit) * 24'(100 - `PSTB_AUX_MARGIN_PCT);
  assign highScaled = 24'(highLimit) * 24'(100 + `PSTB_AUX_MARGIN_PCT);

  // flags only count while a fresh sample is presented
  assign lowWarn = sampleValid && (sampleScaled < lowScaled);
  assign highWarn = sampleValid && (sampleScaled > highScaled);
  assign lowFault = sampleValid && (sample < lowLimit);
  assign highFault = sampleValid && (sample > highLimit);

endmodule : pstb_aux_monitor

`default_nettype wire

/* File: logic/pstb_cfg.svh */
`ifndef PSTB_CFG_SVH
`define PSTB_CFG_SVH

// ****************************************
// command codes of the bank
// ****************************************
`define PSTB_CMD_TEMP 8'h7D
`define PSTB_CMD_CML 8'h7E
`define PSTB_CMD_MFR 8'h80
`define PSTB_CMD_VIN 8'h88
`define PSTB_CMD_IIN 8'h89

// ****************************************
// reset values
// ****************************************
`define PSTB_STATUS_RESET 8'h00
`define PSTB_WORD_RESET 16'h0000

// ****************************************
// temperature status bits
// ****************************************
`define PSTB_TEMP_OVERHEAT_FAULT_BIT 7
`define PSTB_TEMP_OT_WARN_BIT 6
`define PSTB_TEMP_UT_WARN_BIT 5
`define PSTB_TEMP_UNDERCOOL_FAULT_BIT 4

// ****************************************
// communication error bits
// ****************************************
`define PSTB_CML_BAD_CODE_BIT 7
`define PSTB_CML_BAD_DATA_BIT 6
`define PSTB_CML_PEC_BIT 5
`define PSTB_CML_OTHER_BIT 1

// ****************************************
// vendor status bits
// ****************************************
`define PSTB_MFR_BUS_ERR_BIT 6
`define PSTB_MFR_AUX_UV_WARN_BIT 5
`define PSTB_MFR_AUX_OV_WARN_BIT 4
`define PSTB_MFR_SYNC_LOST_BIT 3
`define PSTB_MFR_AUX_UV_FAULT_BIT 1
`define PSTB_MFR_AUX_OV_FAULT_BIT 0

// ****************************************
// telemetry word layout and aux margin
// ****************************************
`define PSTB_LIN_EXP_MSB 15
`define PSTB_LIN_EXP_LSB 11
`define PSTB_LIN_MANT_MSB 10
`define PSTB_AUX_MARGIN_PCT 10

`endif

/* File: logic/pstb_linear11.sv */
`include "pstb_cfg.svh"
`default_nettype none

module pstb_linear11
  import pstb_pkg::*;
#(
  parameter logic signed [4:0] BASE_EXP = 5'sh00
)
(
  input wire logic [15:0] raw,
  output var pstb_lin11_t word
);

  // smallest right shift that keeps the value inside a positive 11-bit mantissa
  // the shift drops low bits: resolution is traded for range on large values
  always_comb
  begin
    logic [2:0] shift;
    logic [15:0] scaled;
    shift = 3'h6;
    scaled = raw >> 6;
    for (int s = 6; s >= 0; s--)
    begin
      if ((raw >> s) < 16'h0400)
      begin
        shift = 3'(s);
        scaled = raw >> s;
      end
    end
    word.exponent = BASE_EXP + $signed({2'h0, shift});
    word.mantissa = $signed(scaled[`PSTB_LIN_MANT_MSB:0]);
  end

endmodule : pstb_linear11

`default_nettype wire

/* File: logic/pstb_pkg.sv */
`default_nettype none

package pstb_pkg;

  // which register a command code selects
  typedef enum logic [2:0] {
    PSTB_SEL_NONE,
    PSTB_SEL_TEMP,
    PSTB_SEL_CML,
    PSTB_SEL_MFR,
    PSTB_SEL_VIN,
    PSTB_SEL_IIN
  } pstb_sel_t;

  // linear-11 telemetry word
  typedef struct packed {
    logic signed [4:0] exponent;
    logic signed [10:0] mantissa;
  } pstb_lin11_t;

endpackage : pstb_pkg

`default_nettype wire

/* File: logic/pstb_status_bank.sv */
// Functional notes
// - temperature status byte per page, read only, resets to zero
// - temperature bits: 7 overheat fault, 6/5 warnings, 4 undercool fault
// - one global comms error byte, read only, resets to zero
// - comms bit 7 on invalid or unsupported command code
// - comms bit 6 on invalid or unsupported data
// - comms bit 5 on packet error check failure
// - comms bit 1 on write to read-only command or other fault
// - one global vendor status byte, read only, resets to zero
// - vendor bit 6 on inter-chip bus error; bits 7 and 2 unused
// - warning bits 5/4 when aux input passes limits by ten percent
// - fault bits 1/0 when aux input passes its configured limits
// - vendor bit 3 on loss of external clock sync
// - input voltage word, linear-11, read only, no defined reset
// - input current word, linear-11, read only, amperes
// - telemetry is signed mantissa times two to signed exponent
// - summary other bit set when any status byte bit set
// - summary temperature bit set on any temperature flag
// - summary comms bit set on any comms flag
`include "pstb_cfg.svh"
`default_nettype none

module pstb_status_bank
  import pstb_pkg::*;
#(
  parameter int PAGES = 2,
  parameter logic signed [4:0] VIN_EXP = 5'sh1E,
  parameter logic signed [4:0] IIN_EXP = 5'sh1C
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cmdStrobe,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic [$clog2(PAGES)-1:0] cmdPage,
  input wire logic badCodeEvent,
  input wire logic badDataEvent,
  input wire logic pecFailEvent,
  input wire logic otherCommEvent,
  input wire logic clearFaults,
  input wire logic [PAGES-1:0] overheatFault,
  input wire logic [PAGES-1:0] overheatWarning,
  input wire logic [PAGES-1:0] undercoolWarning,
  input wire logic [PAGES-1:0] undercoolFault,
  input wire logic interchipBusError,
  input wire logic syncLost,
  input wire logic auxSampleValid,
  input wire logic [15:0] auxMonitorInput,
  input wire logic [15:0] auxMonitorLowLimit,
  input wire logic [15:0] auxMonitorHighLimit,
  input wire logic vinValid,
  input wire logic [15:0] vinRaw,
  input wire logic iinValid,
  input wire logic [15:0] iinRaw,
  output logic rspValid,
  output logic rspHit,
  output logic rspTwoBytes,
  output logic [15:0] rspData,
  output logic [PAGES-1:0] statusOther,
  output logic [PAGES-1:0] statusTemp,
  output logic statusComm
);

  // ****************************************
  // state
  // ****************************************

  typedef struct packed {
    logic [PAGES-1:0][7:0] temp;
    logic [7:0] cml;
    logic [7:0] mfr;
    logic [15:0] vin;
    logic [15:0] iin;
    logic rspValid;
    logic rspHit;
    logic rspTwoBytes;
    logic [15:0] rspData;
    logic [PAGES-1:0] statusOther;
    logic [PAGES-1:0] statusTemp;
    logic statusComm;
  } pstb_state_t;

  pstb_state_t state;
  pstb_state_t next_state;

  pstb_sel_t sel;
  pstb_lin11_t vinWord;
  pstb_lin11_t iinWord;
  logic auxLowWarn;
  logic auxHighWarn;
  logic auxLowFault;
  logic auxHighFault;

  // read answer pieces, settled ahead of the state register
  logic readHit;
  logic readTwoBytes;
  logic [15:0] readData;
  logic pageInRange;
  logic writeRefused;

  // ****************************************
  // helpers
  // ****************************************

  // aux input limit checks
  pstb_aux_monitor auxMonitor
  (
    .sampleValid(auxSampleValid),
    .sample(auxMonitorInput),
    .lowLimit(auxMonitorLowLimit),
    .highLimit(auxMonitorHighLimit),
    .lowWarn(auxLowWarn),
    .highWarn(auxHighWarn),
    .lowFault(auxLowFault),
    .highFault(auxHighFault)
  );

  // raw measurements to telemetry words
  pstb_linear11 #(
    .BASE_EXP(VIN_EXP)
  ) vinEncoder
  (
    .raw(vinRaw),
    .word(vinWord)
  );

  pstb_linear11 #(
    .BASE_EXP(IIN_EXP)
  ) iinEncoder
  (
    .raw(iinRaw),
    .word(iinWord)
  );

  // command code decode; codes outside the bank belong to other banks
  always_comb
  begin
    unique case (cmdCode)
      `PSTB_CMD_TEMP: sel = PSTB_SEL_TEMP;
      `PSTB_CMD_CML: sel = PSTB_SEL_CML;
      `PSTB_CMD_MFR: sel = PSTB_SEL_MFR;
      `PSTB_CMD_VIN: sel = PSTB_SEL_VIN;
      `PSTB_CMD_IIN: sel = PSTB_SEL_IIN;
      default: sel = PSTB_SEL_NONE;
    endcase
  end

  // ****************************************
  // page check and write refusal
  // ****************************************

  // a page beyond the last one reads as zero rather than as a stray byte
  assign pageInRange = (32'(cmdPage) < 32'(PAGES));

  // every code in this bank is read only, so any write to it is refused
  assign writeRefused = cmdStrobe && cmdWrite && readHit;

  // ****************************************
  // read answer
  // ****************************************

  // built from the registered bytes: an event on the strobe edge shows in the next read
  // reads leave the bytes alone, so a flag survives any number of reads
  always_comb
  begin
    readHit = (sel != PSTB_SEL_NONE);
    readTwoBytes = 1'b0;
    readData = `PSTB_WORD_RESET;
    if (!cmdWrite)
    begin
      unique case (sel)
        PSTB_SEL_TEMP: readData = pageInRange ? {8'h00, state.temp[cmdPage]} : `PSTB_WORD_RESET;
        PSTB_SEL_CML: readData = {8'h00, state.cml};
        PSTB_SEL_MFR: readData = {8'h00, state.mfr};
        PSTB_SEL_VIN:
        begin
          readData = state.vin;
          readTwoBytes = 1'b1;
        end
        PSTB_SEL_IIN:
        begin
          readData = state.iin;
          readTwoBytes = 1'b1;
        end
        PSTB_SEL_NONE: readData = `PSTB_WORD_RESET;
      endcase
    end
  end

  // ****************************************
  // next state
  // ****************************************

  always_comb
  begin
    next_state = state;

    // clear first so that a same-cycle event below wins over it
    if (clearFaults)
    begin
      for (int p = 0; p < PAGES; p++)
      begin
        next_state.temp[p] = `PSTB_STATUS_RESET;
      end
      next_state.cml = `PSTB_STATUS_RESET;
      next_state.mfr = `PSTB_STATUS_RESET;
    end

    // temperature flags per page; low nibble never set
    for (int p = 0; p < PAGES; p++)
    begin
      if (overheatFault[p])
      begin
        next_state.temp[p][`PSTB_TEMP_OVERHEAT_FAULT_BIT] = 1'b1;
      end
      if (overheatWarning[p])
      begin
        next_state.temp[p][`PSTB_TEMP_OT_WARN_BIT] = 1'b1;
      end
      if (undercoolWarning[p])
      begin
        next_state.temp[p][`PSTB_TEMP_UT_WARN_BIT] = 1'b1;
      end
      if (undercoolFault[p])
      begin
        next_state.temp[p][`PSTB_TEMP_UNDERCOOL_FAULT_BIT] = 1'b1;
      end
    end

    // communication errors, sticky
    if (badCodeEvent)
    begin
      next_state.cml[`PSTB_CML_BAD_CODE_BIT] = 1'b1;
    end
    if (badDataEvent)
    begin
      next_state.cml[`PSTB_CML_BAD_DATA_BIT] = 1'b1;
    end
    if (pecFailEvent)
    begin
      next_state.cml[`PSTB_CML_PEC_BIT] = 1'b1;
    end
    // refused writes and any unlisted fault from the protocol engine
    if (otherCommEvent || writeRefused)
    begin
      next_state.cml[`PSTB_CML_OTHER_BIT] = 1'b1;
    end

    // vendor faults, sticky
    if (interchipBusError)
    begin
      next_state.mfr[`PSTB_MFR_BUS_ERR_BIT] = 1'b1;
    end
    if (auxLowWarn)
    begin
      next_state.mfr[`PSTB_MFR_AUX_UV_WARN_BIT] = 1'b1;
    end
    if (auxHighWarn)
    begin
      next_state.mfr[`PSTB_MFR_AUX_OV_WARN_BIT] = 1'b1;
    end
    if (syncLost)
    begin
      next_state.mfr[`PSTB_MFR_SYNC_LOST_BIT] = 1'b1;
    end
    if (auxLowFault)
    begin
      next_state.mfr[`PSTB_MFR_AUX_UV_FAULT_BIT] = 1'b1;
    end
    if (auxHighFault)
    begin
      next_state.mfr[`PSTB_MFR_AUX_OV_FAULT_BIT] = 1'b1;
    end

    // telemetry follows the latest valid measurement
    if (vinValid)
    begin
      next_state.vin = vinWord;
    end
    if (iinValid)
    begin
      next_state.iin = iinWord;
    end

    // summaries track the bytes in the same cycle they change
    next_state.statusComm = |next_state.cml;
    for (int p = 0; p < PAGES; p++)
    begin
      next_state.statusTemp[p] = |next_state.temp[p];
      next_state.statusOther[p] = |{next_state.temp[p], next_state.cml, next_state.mfr};
    end

    // read answer, one cycle after the strobe, for one cycle only
    next_state.rspValid = cmdStrobe;
    next_state.rspHit = 1'b0;
    next_state.rspTwoBytes = 1'b0;
    next_state.rspData = `PSTB_WORD_RESET;
    if (cmdStrobe)
    begin
      next_state.rspHit = readHit;
      next_state.rspTwoBytes = readTwoBytes;
      next_state.rspData = readData;
    end

    // reset clears status and answers; telemetry words keep no reset value
    if (srst)
    begin
      for (int p = 0; p < PAGES; p++)
      begin
        next_state.temp[p] = `PSTB_STATUS_RESET;
      end
      next_state.cml = `PSTB_STATUS_RESET;
      next_state.mfr = `PSTB_STATUS_RESET;
      next_state.rspValid = 1'b0;
      next_state.rspHit = 1'b0;
      next_state.rspTwoBytes = 1'b0;
      next_state.rspData = `PSTB_WORD_RESET;
      next_state.statusOther = '0;
      next_state.statusTemp = '0;
      next_state.statusComm = 1'b0;
    end
  end

  // ****************************************
  // registers and outputs
  // ****************************************

  always_ff @(posedge clk)
  begin
    state <= next_state;
  end

  // every output straight from the state register
  assign rspValid = state.rspValid;
  assign rspHit = state.rspHit;
  assign rspTwoBytes = state.rspTwoBytes;
  assign rspData = state.rspData;
  assign statusOther = state.statusOther;
  assign statusTemp = state.statusTemp;
  assign statusComm = state.statusComm;

endmodule : pstb_status_bank

`default_nettype wire

/* File: tb/pstb_host_decoder.sv */
`default_nettype none
// ****************************************
// host side decode of a telemetry word
// ****************************************
module pstb_host_decoder
  import pstb_pkg::*;
(
  input wire logic [15:0] word,
  output var int sixteenths
);
  pstb_lin11_t w;
  int sh;
  // value kept in sixteenths so negative exponents down to -4 stay exact
  always_comb
  begin
    w = word;
    sh = int'(w.exponent) + 4;
    sixteenths = (sh >= 0) ? (int'(w.mantissa) <<< sh) : (int'(w.mantissa) >>> (-sh));
  end
endmodule : pstb_host_decoder
`default_nettype wire

/* File: tb/pstb_status_bank_properties.sv */
`default_nettype none
// ****************************************
// port checks of the status bank
// ****************************************
module pstb_status_bank_checker
#(
  parameter int PAGES = 2
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic cmdStrobe,
  input wire logic cmdWrite,
  input wire logic [7:0] cmdCode,
  input wire logic badCodeEvent,
  input wire logic badDataEvent,
  input wire logic pecFailEvent,
  input wire logic otherCommEvent,
  input wire logic clearFaults,
  input wire logic [PAGES-1:0] overheatFault,
  input wire logic interchipBusError,
  input wire logic syncLost,
  input wire logic rspValid,
  input wire logic rspHit,
  input wire logic rspTwoBytes,
  input wire logic [15:0] rspData,
  input wire logic [PAGES-1:0] statusOther,
  input wire logic [PAGES-1:0] statusTemp,
  input wire logic statusComm
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // a strobe naming one of this bank's codes
  sequence s_bank_cmd;
    cmdStrobe && (cmdCode inside {8'h7D, 8'h7E, 8'h80, 8'h88, 8'h89});
  endsequence
  sequence s_comm_event;
    badCodeEvent || badDataEvent || pecFailEvent || otherCommEvent;
  endsequence
  property p_answer;
    cmdStrobe |=> rspValid;
  endproperty
  property p_quiet;
    !cmdStrobe |=> !rspValid && rspData == 16'h0000;
  endproperty
  property p_hit;
    s_bank_cmd |=> rspHit;
  endproperty
  property p_read_only;
    s_bank_cmd ##0 cmdWrite |=> rspData == 16'h0000 && statusComm;
  endproperty
  property p_words;
    s_bank_cmd ##0 !cmdWrite |=> rspTwoBytes == ($past(cmdCode[7]) && $past(cmdCode[3]));
  endproperty
  property p_byte;
    rspValid && !rspTwoBytes |-> rspData[15:8] == 8'h00;
  endproperty
  property p_comm;
    s_comm_event |=> statusComm;
  endproperty
  property p_sticky;
    statusComm && !clearFaults |=> statusComm;
  endproperty
  property p_temp;
    overheatFault != '0 |=> (statusTemp & $past(overheatFault)) == $past(overheatFault);
  endproperty
  property p_other;
    interchipBusError || syncLost |=> &statusOther;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after strobe");
  a_quiet: assert property (p_quiet) else $error("answer without strobe");
  a_hit: assert property (p_hit) else $error("bank code not claimed");
  a_read_only: assert property (p_read_only) else $error("write not refused");
  a_words: assert property (p_words) else $error("word length flag wrong");
  a_byte: assert property (p_byte) else $error("byte read upper half not zero");
  a_comm: assert property (p_comm) else $error("comms summary missed");
  a_sticky: assert property (p_sticky) else $error("comms flag dropped");
  a_temp: assert property (p_temp) else $error("temperature summary missed");
  a_other: assert property (p_other) else $error("other summary missed");
endmodule : pstb_status_bank_checker

bind pstb_status_bank pstb_status_bank_checker #(.PAGES(PAGES)) u_checker (.clk, .srst, .cmdStrobe,
  .cmdWrite, .cmdCode, .badCodeEvent, .badDataEvent, .pecFailEvent, .otherCommEvent, .clearFaults,
  .overheatFault, .interchipBusError, .syncLost, .rspValid, .rspHit, .rspTwoBytes, .rspData,
  .statusOther, .statusTemp, .statusComm);
`default_nettype wire

/* File: tb/pstb_status_bank_tb_top.sv */
`default_nettype none
// ****************************************
// bench top
// ****************************************
module pstb_status_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, srst = 1'b1, cmdStrobe = 1'b0, cmdWrite = 1'b0, cmdPage = 1'b0;
  logic [7:0] cmdCode = 8'h00;
  logic badCodeEvent = 1'b0, badDataEvent = 1'b0, pecFailEvent = 1'b0, otherCommEvent = 1'b0;
  logic clearFaults = 1'b0, interchipBusError = 1'b0, syncLost = 1'b0;
  logic [1:0] overheatFault = 2'h0, overheatWarning = 2'h0, undercoolWarning = 2'h0, undercoolFault = 2'h0;
  logic auxSampleValid = 1'b0, vinValid = 1'b0, iinValid = 1'b0;
  logic [15:0] auxMonitorInput = 16'h0000, auxMonitorLowLimit = 16'h03E8, auxMonitorHighLimit = 16'h07D0;
  logic [15:0] vinRaw = 16'h01F4, iinRaw = 16'h0BB8, rspData, lastWord = 16'h0000;
  logic rspValid, rspHit, rspTwoBytes, statusComm;
  logic [1:0] statusOther, statusTemp;
  logic [15:0] samples [4] = '{16'h03B6, 16'h0352, 16'h0834, 16'h08FC};
  logic [15:0] expects [4] = '{16'h004A, 16'h006A, 16'h006B, 16'h007B};
  int decoded, miscompares = 0, compares = 0;

  always #2 clk = ~clk;

  pstb_status_bank #(.PAGES(2)) dut (.clk, .srst, .cmdStrobe, .cmdWrite, .cmdCode, .cmdPage, .badCodeEvent,
    .badDataEvent, .pecFailEvent, .otherCommEvent, .clearFaults, .overheatFault, .overheatWarning,
    .undercoolWarning, .undercoolFault, .interchipBusError, .syncLost, .auxSampleValid, .auxMonitorInput,
    .auxMonitorLowLimit, .auxMonitorHighLimit, .vinValid, .vinRaw, .iinValid, .iinRaw, .rspValid, .rspHit,
    .rspTwoBytes, .rspData, .statusOther, .statusTemp, .statusComm);
  pstb_host_decoder host (.word(lastWord), .sixteenths(decoded));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one command, answer looked at in its single valid cycle
  task cmd(input logic wr, input logic [7:0] code, input logic pg, input logic [15:0] data, input logic [1:0] fl);
    @(negedge clk);
    cmdStrobe = 1'b1;
    cmdWrite = wr;
    cmdCode = code;
    cmdPage = pg;
    @(negedge clk);
    cmdStrobe = 1'b0;
    lastWord = rspData;
    check({rspValid, rspHit, rspTwoBytes}, {1'b1, fl});
    check(rspData, data);
  endtask : cmd

  task results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // main sequence: every flag is a one-cycle pulse, read back after it
  initial
  begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    cmd(1'b0, 8'h7D, 1'b0, 16'h0000, 2'b10);
    cmd(1'b0, 8'h7D, 1'b1, 16'h0000, 2'b10);
    cmd(1'b0, 8'h7E, 1'b0, 16'h0000, 2'b10);
    cmd(1'b0, 8'h80, 1'b0, 16'h0000, 2'b10);
    check(statusOther, 2'b00);
    $display("test reset done");
    @(negedge clk) overheatFault = 2'b01;
    @(negedge clk) overheatFault = 2'b00;
    check(statusTemp, 2'b01);
    cmd(1'b0, 8'h7D, 1'b0, 16'h0080, 2'b10);
    @(negedge clk) overheatWarning = 2'b10;
    @(negedge clk) overheatWarning = 2'b00;
    cmd(1'b0, 8'h7D, 1'b1, 16'h0040, 2'b10);
    @(negedge clk) undercoolWarning = 2'b01;
    @(negedge clk) undercoolWarning = 2'b00;
    cmd(1'b0, 8'h7D, 1'b0, 16'h00A0, 2'b10);
    @(negedge clk) undercoolFault = 2'b10;
    @(negedge clk) undercoolFault = 2'b00;
    cmd(1'b0, 8'h7D, 1'b1, 16'h0050, 2'b10);
    check(statusTemp, 2'b11);
    $display("test temperature done");
    @(negedge clk) badCodeEvent = 1'b1;
    @(negedge clk) badCodeEvent = 1'b0;
    check(statusComm, 1'b1);
    cmd(1'b0, 8'h7E, 1'b0, 16'h0080, 2'b10);
    @(negedge clk) badDataEvent = 1'b1;
    @(negedge clk) badDataEvent = 1'b0;
    cmd(1'b0, 8'h7E, 1'b0, 16'h00C0, 2'b10);
    @(negedge clk) pecFailEvent = 1'b1;
    @(negedge clk) pecFailEvent = 1'b0;
    cmd(1'b0, 8'h7E, 1'b0, 16'h00E0, 2'b10);
    cmd(1'b1, 8'h7D, 1'b0, 16'h0000, 2'b10);
    cmd(1'b0, 8'h55, 1'b0, 16'h0000, 2'b00);
    cmd(1'b0, 8'h7E, 1'b0, 16'h00E2, 2'b10);
    @(negedge clk) clearFaults = 1'b1;
    @(negedge clk) clearFaults = 1'b0;
    cmd(1'b0, 8'h7E, 1'b0, 16'h0000, 2'b10);
    check(statusOther, 2'b00);
    check(statusComm, 1'b0);
    @(negedge clk) otherCommEvent = 1'b1;
    @(negedge clk) otherCommEvent = 1'b0;
    check(statusComm, 1'b1);
    cmd(1'b0, 8'h7E, 1'b0, 16'h0002, 2'b10);
    $display("test comms done");
    @(negedge clk) interchipBusError = 1'b1;
    @(negedge clk) interchipBusError = 1'b0;
    cmd(1'b0, 8'h80, 1'b0, 16'h0040, 2'b10);
    @(negedge clk) syncLost = 1'b1;
    @(negedge clk) syncLost = 1'b0;
    cmd(1'b0, 8'h80, 1'b0, 16'h0048, 2'b10);
    check(statusOther, 2'b11);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      auxSampleValid = 1'b1;
      auxMonitorInput = samples[i];
      @(negedge clk) auxSampleValid = 1'b0;
      cmd(1'b0, 8'h80, 1'b0, expects[i], 2'b10);
    end
    // clear and a new event on one edge: the new event must survive
    @(negedge clk);
    clearFaults = 1'b1;
    syncLost = 1'b1;
    @(negedge clk);
    clearFaults = 1'b0;
    syncLost = 1'b0;
    cmd(1'b0, 8'h80, 1'b0, 16'h0008, 2'b10);
    $display("test vendor done");
    @(negedge clk) vinValid = 1'b1;
    @(negedge clk) vinValid = 1'b0;
    cmd(1'b0, 8'h88, 1'b0, 16'hF1F4, 2'b11);
    #1 check(decoded, 32'h000007D0);
    @(negedge clk) iinValid = 1'b1;
    @(negedge clk) iinValid = 1'b0;
    cmd(1'b0, 8'h89, 1'b0, 16'hF2EE, 2'b11);
    #1 check(decoded, 32'h00000BB8);
    $display("test telemetry done");
    @(negedge clk) srst = 1'b1;
    @(negedge clk) srst = 1'b0;
    cmd(1'b0, 8'h80, 1'b0, 16'h0000, 2'b10);
    check(statusOther, 2'b00);
    $display("test second reset done");
    results();
  end

  // watchdog well past the hundred or so cycles the tests take
  initial
  begin
    #8000;
    miscompares++;
    results();
  end
endmodule : pstb_status_bank_tb_top
`default_nettype wire
